/* common/pce_pkg.sv */
`default_nettype none
package pce_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ   = 40_000_000;
   localparam int DEB_MS   = 10;
   localparam int ACT_MS   = 20;
   localparam int DEB_CYC  = DEB_MS * (CLK_HZ / 1000);
   localparam int ACT_CYC  = ACT_MS * (CLK_HZ / 1000);
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_STATUS  = 8'h04;
   localparam logic [7:0] OFF_IRQ_STS = 8'h08;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h0c;
   localparam logic [7:0] OFF_RATE    = 8'h10;
   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int NCH         = 2;
   localparam int CTRL_EN_B   = 0;
   localparam int CTRL_DIS_B  = 1;
   localparam int CTRL_STRIDE = 2;
   localparam int ST_EN_B     = 0;
   localparam int ST_LOCK_B   = 2;
   localparam int ST_SEL_B    = 4;
   localparam int IRQ_WARN_B  = 0;
   localparam int IRQ_FLT_B   = 2;
   localparam int IRQ_W       = 4;
   localparam int RATE_W      = 16;
   localparam logic [15:0] RATE_RST = 16'h0000;
   localparam logic [3:0]  MSK_RST  = 4'h0;
endpackage
`default_nettype wire

/* rtl/pce_top.sv */
// Functional notes
// - Green enabled lamp lit exactly while the channel is enabled.
// - Red disabled lamp lit while the channel is not enabled.
// - Switch in middle position: software enable and disable requests are honoured.
// - Switch pushed up: the channel enable state inverts.
// - Switch in lockout: channel forced off, software enables ignored.
// - Software enable on a locked channel raises a lockout warning.
// - Green active lamp lit while the channel pump runs.
// - Red idle lamp lit while the channel pump is stopped.
// - Yellow load lamp lit while a load is needed or loading.
// - Red fault lamp lit on linear or rotary sensor fault.
// - Red lamp shows serial receive activity, green lamp transmit activity.
// - Two lamps show incoming and outgoing handshake activity.
// - Rates in steps per second.
// - Controller port: trigger in; ready, fault and load required out.
// - The two channels dispense in alternation for continuous flow.
// - System fault output high while no channel is faulted.
// - System ready output only when every channel is ready.
`timescale 1ns/10ps
`default_nettype none
module pce_top #(
   parameter int DEB_CYC = pce_pkg::DEB_CYC,
   parameter int ACT_CYC = pce_pkg::ACT_CYC
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic        ce_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   output logic             irq_out,
   // Channel switches and status
   input  wire logic [1:0]  sw_up_in,
   input  wire logic [1:0]  sw_lock_in,
   input  wire logic [1:0]  pump_run_in,
   input  wire logic [1:0]  load_need_in,
   input  wire logic [1:0]  loading_in,
   input  wire logic [1:0]  lin_flt_in,
   input  wire logic [1:0]  rot_flt_in,
   input  wire logic [1:0]  ch_ready_in,
   input  wire logic [1:0]  stroke_done_in,
   // Channel drive
   output logic      [1:0]  run_out,
   output logic      [15:0] rate_out,
   // Channel lamps
   output logic      [1:0]  en_led_out,
   output logic      [1:0]  dis_led_out,
   output logic      [1:0]  act_led_out,
   output logic      [1:0]  idle_led_out,
   output logic      [1:0]  load_led_out,
   output logic      [1:0]  flt_led_out,
   // Serial lines and lamps
   input  wire logic        ser_rx_in,
   input  wire logic        ser_tx_in,
   input  wire logic        hs_rx_in,
   input  wire logic        hs_tx_in,
   output logic             rx_led_out,
   output logic             tx_led_out,
   output logic             hs_rx_led_out,
   output logic             hs_tx_led_out,
   // Controller port
   input  wire logic        plc_trig_in,
   output logic             plc_ready_out,
   output logic             plc_fault_ok_out,
   output logic             plc_load_req_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam int DCW = $clog2(DEB_CYC + 1);
   localparam int ACW = $clog2(ACT_CYC + 1);

   typedef struct packed {
      logic [1:0]                en;
      logic [1:0]                sw_st;
      logic [1:0][DCW-1:0]       deb_cnt;
      logic [3:0]                line_q;
      logic [3:0][ACW-1:0]       act_cnt;
      logic                      sel;
      logic [pce_pkg::IRQ_W-1:0] sts;
      logic [pce_pkg::IRQ_W-1:0] msk;
      logic [15:0]               rate;
      logic [31:0]               rdata;
      logic                      irq;
      logic [1:0]                run;
      logic [1:0]                en_led;
      logic [1:0]                dis_led;
      logic [1:0]                act_led;
      logic [1:0]                idle_led;
      logic [1:0]                load_led;
      logic [1:0]                flt_led;
      logic [3:0]                ser_led;
      logic                      ready;
      logic                      fault_ok;
      logic                      load_req;
   } pce_st_t;

   pce_st_t s_r;
   pce_st_t s_nxt;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0] tog;
      logic [1:0] warn;
      logic [1:0] mid;
      logic [1:0] flt;
      logic [1:0] usable;
      logic [1:0] en_req;
      logic [1:0] dis_req;
      logic [3:0] lines;
      logic       ctrl_wr;
      tog     = 2'h0;
      warn    = 2'h0;
      mid     = 2'h0;
      flt     = lin_flt_in | rot_flt_in;
      usable  = 2'h0;
      en_req  = 2'h0;
      dis_req = 2'h0;
      lines   = {hs_tx_in, hs_rx_in, ser_tx_in, ser_rx_in};
      ctrl_wr = wr_in && (addr_in == pce_pkg::OFF_CTRL);
      s_nxt   = s_r;
      s_nxt.rdata = 32'h0;

      for (int i = 0; i < pce_pkg::NCH; i++) begin
         // Debounce: raw level must hold for the full count
         if (sw_up_in[i] != s_r.sw_st[i]) begin
            if (s_r.deb_cnt[i] == DCW'(DEB_CYC - 1)) begin
               s_nxt.sw_st[i]   = sw_up_in[i];
               s_nxt.deb_cnt[i] = '0;
            end else begin
               s_nxt.deb_cnt[i] = s_r.deb_cnt[i] + 1'b1;
            end
         end else begin
            s_nxt.deb_cnt[i] = '0;
         end
         tog[i]     = s_nxt.sw_st[i] & ~s_r.sw_st[i];
         mid[i]     = ~sw_up_in[i] & ~s_r.sw_st[i] & ~sw_lock_in[i];
         en_req[i]  = ctrl_wr & wdata_in[i * pce_pkg::CTRL_STRIDE + pce_pkg::CTRL_EN_B];
         dis_req[i] = ctrl_wr & wdata_in[i * pce_pkg::CTRL_STRIDE + pce_pkg::CTRL_DIS_B];
         if (sw_lock_in[i]) begin
            s_nxt.en[i] = 1'b0;
            warn[i]     = en_req[i];
         end else if (tog[i]) begin
            s_nxt.en[i] = ~s_r.en[i];
         end else if (mid[i] && en_req[i]) begin
            s_nxt.en[i] = 1'b1;
         end else if (mid[i] && dis_req[i]) begin
            s_nxt.en[i] = 1'b0;
         end
         usable[i] = s_nxt.en[i] & ch_ready_in[i] & ~flt[i];
      end

      // Serial activity stretchers
      for (int j = 0; j < 4; j++) begin
         s_nxt.line_q[j] = lines[j];
         if (lines[j] != s_r.line_q[j]) begin
            s_nxt.act_cnt[j] = ACW'(ACT_CYC - 1);
         end else if (s_r.act_cnt[j] != '0) begin
            s_nxt.act_cnt[j] = s_r.act_cnt[j] - 1'b1;
         end
         s_nxt.ser_led[j] = (s_nxt.act_cnt[j] != '0);
      end

      // Alternation: hand over at end of stroke or when current one drops out
      if ((stroke_done_in[s_r.sel] || !usable[s_r.sel]) && usable[~s_r.sel]) begin
         s_nxt.sel = ~s_r.sel;
      end
      for (int i = 0; i < pce_pkg::NCH; i++) begin
         s_nxt.run[i] = plc_trig_in & usable[i] & (s_nxt.sel == 1'(i));
      end

      // Interrupt status, set wins over clear
      if (wr_in && addr_in == pce_pkg::OFF_IRQ_STS) begin
         s_nxt.sts = s_r.sts & ~wdata_in[pce_pkg::IRQ_W-1:0];
      end
      s_nxt.sts[pce_pkg::IRQ_WARN_B +: 2] = s_nxt.sts[pce_pkg::IRQ_WARN_B +: 2] | warn;
      s_nxt.sts[pce_pkg::IRQ_FLT_B +: 2]  = s_nxt.sts[pce_pkg::IRQ_FLT_B +: 2] | flt;
      if (wr_in && addr_in == pce_pkg::OFF_IRQ_MSK) begin
         s_nxt.msk = wdata_in[pce_pkg::IRQ_W-1:0];
      end
      s_nxt.irq = |(s_nxt.sts & s_nxt.msk);

      // Rate in steps per second
      if (wr_in && addr_in == pce_pkg::OFF_RATE) begin
         s_nxt.rate = wdata_in[pce_pkg::RATE_W-1:0];
      end

      // Read data
      if (rd_in) begin
         case (addr_in)
            pce_pkg::OFF_STATUS: begin
               s_nxt.rdata[pce_pkg::ST_EN_B +: 2]   = s_r.en;
               s_nxt.rdata[pce_pkg::ST_LOCK_B +: 2] = sw_lock_in;
               s_nxt.rdata[pce_pkg::ST_SEL_B]       = s_r.sel;
            end
            pce_pkg::OFF_IRQ_STS: begin
               s_nxt.rdata[pce_pkg::IRQ_W-1:0] = s_r.sts;
            end
            pce_pkg::OFF_IRQ_MSK: begin
               s_nxt.rdata[pce_pkg::IRQ_W-1:0] = s_r.msk;
            end
            pce_pkg::OFF_RATE: begin
               s_nxt.rdata[pce_pkg::RATE_W-1:0] = s_r.rate;
            end
            default: begin
               s_nxt.rdata = 32'h0;
            end
         endcase
      end

      // Lamps and controller port
      s_nxt.en_led   = s_nxt.en;
      s_nxt.dis_led  = ~s_nxt.en;
      s_nxt.act_led  = pump_run_in;
      s_nxt.idle_led = ~pump_run_in;
      s_nxt.load_led = load_need_in | loading_in;
      s_nxt.flt_led  = flt;
      s_nxt.ready    = &ch_ready_in;
      s_nxt.fault_ok = ~|flt;
      s_nxt.load_req = |(s_nxt.en & load_need_in & ~loading_in);
   end

   // ----------------------------------------------------------------
   // Register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_r      <= '0;
         s_r.rate <= pce_pkg::RATE_RST;
         s_r.msk  <= pce_pkg::MSK_RST;
         s_r.dis_led <= '1;
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   assign rdata_out        = s_r.rdata;
   assign irq_out          = s_r.irq;
   assign run_out          = s_r.run;
   assign rate_out         = s_r.rate;
   assign en_led_out       = s_r.en_led;
   assign dis_led_out      = s_r.dis_led;
   assign act_led_out      = s_r.act_led;
   assign idle_led_out     = s_r.idle_led;
   assign load_led_out     = s_r.load_led;
   assign flt_led_out      = s_r.flt_led;
   assign rx_led_out       = s_r.ser_led[0];
   assign tx_led_out       = s_r.ser_led[1];
   assign hs_rx_led_out    = s_r.ser_led[2];
   assign hs_tx_led_out    = s_r.ser_led[3];
   assign plc_ready_out    = s_r.ready;
   assign plc_fault_ok_out = s_r.fault_ok;
   assign plc_load_req_out = s_r.load_req;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   property p_en_led;
      en_led_out == s_r.en;
   endproperty
   a_en_led: assert property (p_en_led) else $error("enabled lamp mismatch");

   property p_dis_led;
      dis_led_out == ~en_led_out;
   endproperty
   a_dis_led: assert property (p_dis_led) else $error("disabled lamp mismatch");

   property p_serial_en;
      ce_in && wr_in && addr_in == pce_pkg::OFF_CTRL && wdata_in[0] && !wdata_in[1]
         && !sw_lock_in[0] && !sw_up_in[0] && !s_r.sw_st[0] |=> en_led_out[0];
   endproperty
   a_serial_en: assert property (p_serial_en) else $error("serial enable lost");

   property p_toggle;
      ce_in && !sw_lock_in[0] && sw_up_in[0] && !s_r.sw_st[0]
         && s_r.deb_cnt[0] == DCW'(DEB_CYC - 1) |=> s_r.en[0] != $past(s_r.en[0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not invert");

   property p_lock;
      ce_in && sw_lock_in[1] |=> !en_led_out[1] && dis_led_out[1];
   endproperty
   a_lock: assert property (p_lock) else $error("locked channel enabled");

   property p_warn;
      ce_in && wr_in && addr_in == pce_pkg::OFF_CTRL
         && wdata_in[pce_pkg::CTRL_STRIDE + pce_pkg::CTRL_EN_B] && sw_lock_in[1]
         |=> s_r.sts[pce_pkg::IRQ_WARN_B + 1];
   endproperty
   a_warn: assert property (p_warn) else $error("lockout warning missing");

   property p_act;
      ce_in |=> act_led_out == $past(pump_run_in) && idle_led_out == ~act_led_out;
   endproperty
   a_act: assert property (p_act) else $error("active or idle lamp wrong");

   property p_flt;
      ce_in |=> flt_led_out == $past(lin_flt_in | rot_flt_in)
         && plc_fault_ok_out == ~|flt_led_out;
   endproperty
   a_flt: assert property (p_flt) else $error("fault lamp or output wrong");

   property p_rx;
      ce_in && ser_rx_in != s_r.line_q[0] |=> rx_led_out;
   endproperty
   a_rx: assert property (p_rx) else $error("receive lamp not lit");

   property p_alt;
      $onehot0(run_out);
   endproperty
   a_alt: assert property (p_alt) else $error("both channels running");

   property p_ready;
      ce_in |=> plc_ready_out == &$past(ch_ready_in);
   endproperty
   a_ready: assert property (p_ready) else $error("system ready wrong");

   property p_load;
      ce_in |=> load_led_out == $past(load_need_in | loading_in);
   endproperty
   a_load: assert property (p_load) else $error("load lamp wrong");

   property p_load_req;
      ce_in |=> plc_load_req_out == |(en_led_out & $past(load_need_in & ~loading_in));
   endproperty
   a_load_req: assert property (p_load_req) else $error("load required output wrong");

   property p_hs_tx;
      ce_in && hs_tx_in != s_r.line_q[3] |=> hs_tx_led_out;
   endproperty
   a_hs_tx: assert property (p_hs_tx) else $error("handshake lamp not lit");

   property p_rate;
      ce_in && wr_in && addr_in == pce_pkg::OFF_RATE |=> rate_out == $past(wdata_in[pce_pkg::RATE_W-1:0]);
   endproperty
   a_rate: assert property (p_rate) else $error("rate not taken");

   property p_no_trig;
      ce_in && !plc_trig_in |=> run_out == 2'h0;
   endproperty
   a_no_trig: assert property (p_no_trig) else $error("channel runs without trigger");

   property p_flt_sts;
      ce_in && (lin_flt_in[1] || rot_flt_in[1]) |=> s_r.sts[pce_pkg::IRQ_FLT_B + 1];
   endproperty
   a_flt_sts: assert property (p_flt_sts) else $error("fault status not set");

   property p_rdata_once;
      ce_in && !rd_in |=> rdata_out == 32'h0;
   endproperty
   a_rdata_once: assert property (p_rdata_once) else $error("read data outside its cycle");

   property p_freeze;
      !ce_in |=> $stable(s_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   c_freeze: cover property (!ce_in && wr_in);
   c_toggle: cover property (ce_in && $rose(s_r.sw_st[0]));
   c_warn: cover property ($rose(s_r.sts[pce_pkg::IRQ_WARN_B]));
   c_swap: cover property ($changed(s_r.sel) && plc_trig_in);
   c_irq: cover property ($rose(irq_out));
endmodule // pce_top
`default_nettype wire

/* test/pce_panel_model.sv */
`timescale 1ns/10ps
`default_nettype none
// --------------------------------
// Toggle switch with contact bounce
// --------------------------------
module pce_panel_model #(
   parameter int HOLD = 12
) (
   input  wire logic       clk_in,
   input  wire logic [1:0] press_in,
   output logic      [1:0] sw_up_out
);
   int         cnt;
   logic [1:0] ch;
   logic       lvl;
   initial begin
      cnt       = 0;
      ch        = 2'b00;
      sw_up_out = 2'b00;
   end
   // Short chatter at make and break, held firm in between
   always_comb begin
      if (cnt == 0) begin
         lvl = 1'b0;
      end else if (cnt > HOLD + 3 || cnt < 4) begin
         lvl = cnt[0];
      end else begin
         lvl = 1'b1;
      end
   end
   always @(posedge clk_in) begin
      if (press_in != 2'b00 && cnt == 0) begin
         ch  <= press_in;
         cnt <= HOLD + 6;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      sw_up_out <= lvl ? ch : 2'b00;
   end
endmodule // pce_panel_model
`default_nettype wire

/* test/pce_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pce_top_tb;
   localparam int ACT = 6;
   logic        clk_in, srst_in, wr_in, rd_in, irq_out, plc_trig_in;
   logic        plc_ready_out, plc_fault_ok_out, plc_load_req_out;
   logic [7:0]  addr_in;
   logic [31:0] wdata_in, rdata_out, v;
   logic [1:0]  press, sw_up, sw_lock_in, pump_run_in, load_need_in, loading_in, lin_flt_in, rot_flt_in;
   logic [1:0]  ch_ready_in, stroke_done_in, run_out, en_led_out, dis_led_out, act_led_out, idle_led_out;
   logic [1:0]  load_led_out, flt_led_out;
   logic [15:0] rate_out;
   logic [3:0]  lines, act_leds;
   logic        ce;
   int          n_mismatch, tests_run;

   pce_top #(.DEB_CYC(4), .ACT_CYC(ACT)) u_pce_top (
      .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .sw_up_in(sw_up),
      .sw_lock_in(sw_lock_in), .pump_run_in(pump_run_in), .load_need_in(load_need_in),
      .loading_in(loading_in), .lin_flt_in(lin_flt_in), .rot_flt_in(rot_flt_in),
      .ch_ready_in(ch_ready_in), .stroke_done_in(stroke_done_in), .run_out(run_out), .rate_out(rate_out),
      .en_led_out(en_led_out), .dis_led_out(dis_led_out), .act_led_out(act_led_out),
      .idle_led_out(idle_led_out), .load_led_out(load_led_out), .flt_led_out(flt_led_out),
      .ser_rx_in(lines[3]), .ser_tx_in(lines[2]), .hs_rx_in(lines[1]), .hs_tx_in(lines[0]),
      .rx_led_out(act_leds[3]), .tx_led_out(act_leds[2]), .hs_rx_led_out(act_leds[1]),
      .hs_tx_led_out(act_leds[0]), .plc_trig_in(plc_trig_in), .plc_ready_out(plc_ready_out),
      .plc_fault_ok_out(plc_fault_ok_out), .plc_load_req_out(plc_load_req_out));
   pce_panel_model u_pce_panel_model (.clk_in(clk_in), .press_in(press), .sw_up_out(sw_up));

   // --------------------------------
   // Access tasks
   // --------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      v = rdata_out;
   endtask
   task automatic push(input logic [1:0] m);
      @(posedge clk_in);
      press <= m;
      @(posedge clk_in);
      press <= 2'b00;
      tick(40);
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      n_mismatch++;
      end_sim();
   end
   // --------------------------------
   // Scenarios
   // --------------------------------
   initial begin
      {srst_in, wr_in, rd_in, plc_trig_in, addr_in, wdata_in} = {4'b1000, 8'h00, 32'h0};
      {press, sw_lock_in, pump_run_in, load_need_in, loading_in} = '0;
      {lin_flt_in, rot_flt_in, ch_ready_in, stroke_done_in, lines} = '0;
      ce         = 1'b1;
      n_mismatch = 0;
      tests_run  = 0;
      repeat (12) @(posedge clk_in);
      srst_in <= 1'b0;
      tick(3);
      chk("en_led", en_led_out, 0);
      chk("dis_led", dis_led_out, 3);
      wr(pce_pkg::OFF_CTRL, 1);
      tick(2);
      chk("en_led", en_led_out, 1);
      chk("dis_led", dis_led_out, 2);
      wr(pce_pkg::OFF_CTRL, 2);
      tick(2);
      chk("en_led", en_led_out, 0);
      @(posedge clk_in);
      sw_lock_in <= 2'b10;
      wr(pce_pkg::OFF_IRQ_MSK, 2);
      wr(pce_pkg::OFF_CTRL, 4);
      tick(3);
      chk("en_led", en_led_out, 0);
      rd(pce_pkg::OFF_IRQ_STS);
      chk("irq_sts", v, 2);
      chk("irq", irq_out, 1);
      wr(pce_pkg::OFF_IRQ_STS, 2);
      tick(3);
      chk("irq", irq_out, 0);
      wr(pce_pkg::OFF_CTRL, 1);
      sw_lock_in <= 2'b11;
      tick(3);
      chk("en_led", en_led_out, 0);
      rd(pce_pkg::OFF_STATUS);
      chk("status", v & 32'hf, 32'hc);
      @(posedge clk_in);
      sw_lock_in <= 2'b00;
      push(2'b10);
      chk("en_led", en_led_out, 2);
      push(2'b10);
      chk("en_led", en_led_out, 0);
      push(2'b01);
      chk("en_led", en_led_out, 1);
      @(posedge clk_in);
      {pump_run_in, load_need_in, loading_in, lin_flt_in, rot_flt_in, ch_ready_in} <= 12'b01_01_10_01_10_01;
      tick(3);
      chk("act_led", act_led_out, 1);
      chk("idle_led", idle_led_out, 2);
      chk("load_led", load_led_out, 3);
      chk("flt_led", flt_led_out, 3);
      chk("fault_ok", plc_fault_ok_out, 0);
      chk("ready", plc_ready_out, 0);
      chk("load_req", plc_load_req_out, 1);
      @(posedge clk_in);
      {lin_flt_in, rot_flt_in, ch_ready_in} <= 6'b00_00_11;
      tick(3);
      chk("fault_ok", plc_fault_ok_out, 1);
      chk("ready", plc_ready_out, 1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         lines[i] <= ~lines[i];
         tick(3);
         chk("act_lamps", act_leds, 4'b0001 << i);
         tick(ACT + 4);
         chk("act_lamps", act_leds, 0);
      end
      wr(pce_pkg::OFF_RATE, 32'h1234);
      rd(pce_pkg::OFF_RATE);
      chk("rate", v, 32'h1234);
      chk("rate_out", rate_out, 16'h1234);
      rd(8'h20);
      chk("unmapped", v, 0);
      tick(1);
      chk("rdata_idle", rdata_out, 0);
      wr(pce_pkg::OFF_CTRL, 5);
      plc_trig_in <= 1'b1;
      tick(4);
      rd(pce_pkg::OFF_STATUS);
      chk("status", v & 32'h1f, 32'h03);
      chk("run", run_out, 1);
      @(posedge clk_in);
      stroke_done_in <= 2'b01;
      @(posedge clk_in);
      stroke_done_in <= 2'b00;
      tick(3);
      chk("run", run_out, 2);
      @(posedge clk_in);
      plc_trig_in <= 1'b0;
      tick(3);
      chk("run", run_out, 0);
      @(posedge clk_in);
      ce <= 1'b0;
      wr(pce_pkg::OFF_RATE, 32'h0055);
      tick(2);
      chk("rate_frozen", rate_out, 16'h1234);
      @(posedge clk_in);
      ce      <= 1'b1;
      srst_in <= 1'b1;
      tick(2);
      chk("dis_led", dis_led_out, 3);
      chk("rate_rst", rate_out, 0);
      @(posedge clk_in);
      srst_in <= 1'b0;
      tick(2);
      chk("en_led", en_led_out, 0);
      chk("dis_led", dis_led_out, 3);
      chk("ready", plc_ready_out, 1);
      end_sim();
   end
endmodule // pce_top_tb
`default_nettype wire
